// >>> include/sfe_map.svh
`ifndef SFE_MAP_SVH
`define SFE_MAP_SVH

// ****************************************************************
// Opcodes of the erase command set
// ****************************************************************
`define SFE_OP_WRITE_ENABLE   8'h06
`define SFE_OP_SECTOR_3B      8'h20
`define SFE_OP_SECTOR_4B      8'h21
`define SFE_OP_HALF_BLOCK_3B  8'h52
`define SFE_OP_HALF_BLOCK_4B  8'h5C
`define SFE_OP_BLOCK_3B       8'hD8
`define SFE_OP_BLOCK_4B       8'hDC
`define SFE_OP_CHIP           8'h60
`define SFE_OP_CHIP_ALT       8'hC7

// ****************************************************************
// Frame lengths in bits, counted from chip select low, and bits per clock rise
// ****************************************************************
`define SFE_OPCODE_BITS       6'h08
`define SFE_ADDR3_FRAME_BITS  6'h20
`define SFE_ADDR4_FRAME_BITS  6'h28
`define SFE_SERIAL_STEP       6'h01
`define SFE_QUAD_STEP         6'h04

// ****************************************************************
// Alignment masks for sector, half block and block, fixed address for chip erase
// ****************************************************************
`define SFE_SECTOR_MASK       32'hFFFF_F000
`define SFE_HALF_BLOCK_MASK   32'hFFFF_8000
`define SFE_BLOCK_MASK        32'hFFFF_0000
`define SFE_CHIP_ADDR         32'h0000_0000

// ****************************************************************
// Reset values and the clear block-protect value
// ****************************************************************
`define SFE_ADDR_RESET        32'h0000_0000
`define SFE_OPCODE_RESET      8'h00
`define SFE_BP_CLEAR          4'h0

// ****************************************************************
// Timing: clock rate and erase times in microseconds
// ****************************************************************
`define SFE_MCLK_MHZ                32'h0000_0032
`define SFE_SECTOR_ERASE_TIME_US    32'h0000_7530
`define SFE_HALF_BLOCK_ERASE_TIME_US 32'h0002_49F0
`define SFE_BLOCK_ERASE_TIME_US     32'h0003_D090
`define SFE_ARRAY_ERASE_TIME_US     32'h001E_8480

`endif

// >>> include/sfe_pkg.sv
package sfe_pkg;

   // ****************************************************************
   // Decoded command kinds
   // ****************************************************************
   typedef enum logic [2:0] {
      SFE_KIND_NONE,
      SFE_KIND_WRITE_ENABLE,
      SFE_KIND_SECTOR,
      SFE_KIND_HALF_BLOCK,
      SFE_KIND_BLOCK,
      SFE_KIND_CHIP
   } sfe_kind_e;

   // Decoder result: kind and whether the opcode itself is 4-byte
   typedef struct packed {
      sfe_kind_e kind;
      logic      addr4;
   } sfe_cmd_s;

   // Erase engine states
   typedef enum logic [1:0] {
      SFE_ST_IDLE,
      SFE_ST_CHECK,
      SFE_ST_ERASE
   } sfe_state_e;

endpackage : sfe_pkg

// >>> src/sfe_erase_seq.sv
`timescale 1ns/1ps
`include "sfe_map.svh"

module sfe_erase_seq #(
   parameter int unsigned SectorEraseCycles =
      `SFE_SECTOR_ERASE_TIME_US * `SFE_MCLK_MHZ,
   parameter int unsigned HalfBlockEraseCycles =
      `SFE_HALF_BLOCK_ERASE_TIME_US * `SFE_MCLK_MHZ,
   parameter int unsigned BlockEraseCycles =
      `SFE_BLOCK_ERASE_TIME_US * `SFE_MCLK_MHZ,
   parameter int unsigned ArrayEraseCycles =
      `SFE_ARRAY_ERASE_TIME_US * `SFE_MCLK_MHZ
) (
   input  wire logic              mclk,
   input  wire logic              resetn,
   input  wire logic              chipSelectN,
   input  wire logic              serialClock,
   input  wire logic [3:0]        sio,
   input  wire logic              quadCommandMode,
   input  wire logic              fourByteAddrMode,
   input  wire logic              extendedAddrBit,
   input  wire logic              protectSchemeSelect,
   input  wire logic [3:0]        blockProtectBits,
   input  wire logic              bpRegionLocked,
   input  wire logic              sectorRegionLocked,
   output logic                   writeEnableLatch,
   output logic                   writeInProgressFlag,
   output sfe_pkg::sfe_kind_e     eraseKind,
   output logic [31:0]            eraseAddr,
   output logic                   eraseSkipLocked,
   output logic                   cmdRejected
);

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [5:0]  syncFirst;
   logic [5:0]  syncSecond;
   logic        sclkPrev;
   logic        csnPrev;
   logic        sclkRise;
   logic        csnRise;
   logic        csnLow;
   logic [3:0]  sioSync;

   // Two flops on the select, clock and data pins before any logic looks at them
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         syncFirst  <= 6'h3F;
         syncSecond <= 6'h3F;
      end else begin
         syncFirst  <= {chipSelectN, serialClock, sio};
         syncSecond <= syncFirst;
      end
   end

   // Edge history of the synchronised clock and select
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sclkPrev <= 1'b1;
         csnPrev  <= 1'b1;
      end else begin
         sclkPrev <= syncSecond[4];
         csnPrev  <= syncSecond[5];
      end
   end

   assign csnLow   = ~syncSecond[5];
   assign sioSync  = syncSecond[3:0];
   assign sclkRise = syncSecond[4] & ~sclkPrev & csnLow;
   assign csnRise  = syncSecond[5] & ~csnPrev;

   // ****************************************************************
   // Frame shifter and bit counter
   // ****************************************************************
   logic [39:0] shiftReg;
   logic [39:0] next_shiftReg;
   logic [5:0]  bitCount;
   logic [5:0]  next_bitCount;
   logic [5:0]  bitStep;
   logic [7:0]  opcode;

   // Serial mode uses line 0 only, quad mode all four lines
   always_comb begin
      if (quadCommandMode) begin
         bitStep       = `SFE_QUAD_STEP;
         next_shiftReg = {shiftReg[35:0], sioSync};
      end else begin
         bitStep       = `SFE_SERIAL_STEP;
         next_shiftReg = {shiftReg[38:0], sioSync[0]};
      end
      if (bitCount < `SFE_ADDR4_FRAME_BITS) begin
         next_bitCount = bitCount + bitStep;
      end else begin
         next_bitCount = 6'h3F;                // Too long for any erase
      end
   end

   // Shift on each clock rise while selected, restart on select low
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         shiftReg <= 40'h00_0000_0000;
         bitCount <= 6'h00;
      end else if (!csnLow) begin
         bitCount <= 6'h00;
      end else if (sclkRise) begin
         shiftReg <= next_shiftReg;
         if (bitCount != 6'h3F) begin
            bitCount <= next_bitCount;
         end
      end
   end

   // Opcode captured when the eighth bit lands
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         opcode <= `SFE_OPCODE_RESET;
      end else if (!csnLow) begin
         if (csnRise) begin
            opcode <= opcode;
         end
      end else if (sclkRise && next_bitCount == `SFE_OPCODE_BITS
                   && bitCount < `SFE_OPCODE_BITS) begin
         opcode <= next_shiftReg[7:0];
      end
   end

   // ****************************************************************
   // Command decode and frame checks
   // ****************************************************************
   sfe_pkg::sfe_cmd_s decoded;
   logic              useAddr4;
   logic [5:0]        frameBits;
   logic [31:0]       rawAddr;
   logic [31:0]       alignedAddr;
   logic              frameValid;

   // Each erase size and width has its own opcode
   always_comb begin
      decoded.addr4 = 1'b0;
      case (opcode)
         `SFE_OP_WRITE_ENABLE: decoded.kind = sfe_pkg::SFE_KIND_WRITE_ENABLE;
         `SFE_OP_SECTOR_3B:    decoded.kind = sfe_pkg::SFE_KIND_SECTOR;
         `SFE_OP_SECTOR_4B: begin
            decoded.kind  = sfe_pkg::SFE_KIND_SECTOR;
            decoded.addr4 = 1'b1;
         end
         `SFE_OP_HALF_BLOCK_3B: decoded.kind = sfe_pkg::SFE_KIND_HALF_BLOCK;
         `SFE_OP_HALF_BLOCK_4B: begin
            decoded.kind  = sfe_pkg::SFE_KIND_HALF_BLOCK;
            decoded.addr4 = 1'b1;
         end
         `SFE_OP_BLOCK_3B:     decoded.kind = sfe_pkg::SFE_KIND_BLOCK;
         `SFE_OP_BLOCK_4B: begin
            decoded.kind  = sfe_pkg::SFE_KIND_BLOCK;
            decoded.addr4 = 1'b1;
         end
         `SFE_OP_CHIP,
         `SFE_OP_CHIP_ALT:     decoded.kind = sfe_pkg::SFE_KIND_CHIP;
         default:              decoded.kind = sfe_pkg::SFE_KIND_NONE;
      endcase
   end

   // Address width and required frame length
   always_comb begin
      useAddr4 = decoded.addr4 | fourByteAddrMode;
      if (useAddr4) begin
         rawAddr   = shiftReg[31:0];
         frameBits = `SFE_ADDR4_FRAME_BITS;
      end else begin
         rawAddr   = {7'h00, extendedAddrBit, shiftReg[23:0]};
         frameBits = `SFE_ADDR3_FRAME_BITS;
      end
      case (decoded.kind)
         sfe_pkg::SFE_KIND_SECTOR: begin
            alignedAddr = rawAddr & `SFE_SECTOR_MASK;
            frameValid  = (bitCount == frameBits);
         end
         sfe_pkg::SFE_KIND_HALF_BLOCK: begin
            alignedAddr = rawAddr & `SFE_HALF_BLOCK_MASK;
            frameValid  = (bitCount == frameBits);
         end
         sfe_pkg::SFE_KIND_BLOCK: begin
            alignedAddr = rawAddr & `SFE_BLOCK_MASK;
            frameValid  = (bitCount == frameBits);
         end
         sfe_pkg::SFE_KIND_CHIP: begin
            alignedAddr = `SFE_CHIP_ADDR;
            frameValid  = (bitCount == `SFE_OPCODE_BITS);
         end
         sfe_pkg::SFE_KIND_WRITE_ENABLE: begin
            alignedAddr = `SFE_ADDR_RESET;
            frameValid  = (bitCount == `SFE_OPCODE_BITS);
         end
         default: begin
            alignedAddr = `SFE_ADDR_RESET;
            frameValid  = 1'b0;
         end
      endcase
   end

   // ****************************************************************
   // Erase engine
   // ****************************************************************
   sfe_pkg::sfe_state_e state;
   logic [31:0]         cycleCount;
   logic [31:0]         eraseLength;
   logic                isErase;
   logic                eraseAccept;
   logic                wrenAccept;
   logic                targetLocked;
   logic                chipBlocked;
   logic                eraseDone;

   assign isErase = (decoded.kind == sfe_pkg::SFE_KIND_SECTOR)
                  | (decoded.kind == sfe_pkg::SFE_KIND_HALF_BLOCK)
                  | (decoded.kind == sfe_pkg::SFE_KIND_BLOCK)
                  | (decoded.kind == sfe_pkg::SFE_KIND_CHIP);
   assign eraseAccept = csnRise & frameValid & isErase & writeEnableLatch
                      & (state == sfe_pkg::SFE_ST_IDLE);
   assign wrenAccept  = csnRise & frameValid
                      & (decoded.kind == sfe_pkg::SFE_KIND_WRITE_ENABLE)
                      & (state == sfe_pkg::SFE_ST_IDLE);
   assign targetLocked = protectSchemeSelect ? sectorRegionLocked
                                             : bpRegionLocked;
   assign chipBlocked  = ~protectSchemeSelect
                       & (blockProtectBits != `SFE_BP_CLEAR);
   assign eraseDone    = (state == sfe_pkg::SFE_ST_ERASE)
                       & (cycleCount == 32'h0000_0000);

   // Self-timed length for each erase size
   always_comb begin
      case (eraseKind)
         sfe_pkg::SFE_KIND_SECTOR:
            eraseLength = 32'(SectorEraseCycles - 1);
         sfe_pkg::SFE_KIND_HALF_BLOCK:
            eraseLength = 32'(HalfBlockEraseCycles - 1);
         sfe_pkg::SFE_KIND_BLOCK:
            eraseLength = 32'(BlockEraseCycles - 1);
         default:
            eraseLength = 32'(ArrayEraseCycles - 1);
      endcase
   end

   // Target latched at select rise, held for probe and array
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         eraseKind <= sfe_pkg::SFE_KIND_NONE;
         eraseAddr <= `SFE_ADDR_RESET;
      end else if (eraseAccept) begin
         eraseKind <= decoded.kind;
         eraseAddr <= alignedAddr;
      end
   end

   // Idle, one cycle of protection check, then the timed erase
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state           <= sfe_pkg::SFE_ST_IDLE;
         cycleCount      <= 32'h0000_0000;
         eraseSkipLocked <= 1'b0;
      end else begin
         case (state)
            sfe_pkg::SFE_ST_IDLE: begin
               if (eraseAccept) begin
                  state <= sfe_pkg::SFE_ST_CHECK;
               end
            end
            sfe_pkg::SFE_ST_CHECK: begin
               cycleCount <= eraseLength;
               if (eraseKind == sfe_pkg::SFE_KIND_CHIP) begin
                  eraseSkipLocked <= protectSchemeSelect;
                  if (chipBlocked) begin
                     state <= sfe_pkg::SFE_ST_IDLE;
                  end else begin
                     state <= sfe_pkg::SFE_ST_ERASE;
                  end
               end else if (targetLocked) begin
                  state <= sfe_pkg::SFE_ST_IDLE;
               end else begin
                  eraseSkipLocked <= 1'b0;
                  state           <= sfe_pkg::SFE_ST_ERASE;
               end
            end
            sfe_pkg::SFE_ST_ERASE: begin
               if (eraseDone) begin
                  state           <= sfe_pkg::SFE_ST_IDLE;
                  eraseSkipLocked <= 1'b0;
               end else begin
                  cycleCount <= cycleCount - 32'h0000_0001;
               end
            end
            default: state <= sfe_pkg::SFE_ST_IDLE;
         endcase
      end
   end

   // Busy flag covers acceptance, check and the whole timed erase
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         writeInProgressFlag <= 1'b0;
      end else if (eraseAccept) begin
         writeInProgressFlag <= 1'b1;
      end else if (eraseDone) begin
         writeInProgressFlag <= 1'b0;
      end else if (state == sfe_pkg::SFE_ST_CHECK) begin
         writeInProgressFlag <= ~(eraseKind == sfe_pkg::SFE_KIND_CHIP
                                  ? chipBlocked : targetLocked);
      end
   end

   // Latch set by write enable, cleared when an erase completes
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         writeEnableLatch <= 1'b0;
      end else if (wrenAccept) begin
         writeEnableLatch <= 1'b1;
      end else if (eraseDone) begin
         writeEnableLatch <= 1'b0;
      end
   end

   // One-cycle pulse when an erase frame is refused
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cmdRejected <= 1'b0;
      end else begin
         cmdRejected <= (csnRise & isErase & ~eraseAccept)
                      | ((state == sfe_pkg::SFE_ST_CHECK)
                         & ((eraseKind == sfe_pkg::SFE_KIND_CHIP)
                            ? chipBlocked : targetLocked));
      end
   end

endmodule : sfe_erase_seq

// >>> test/sfe_erase_properties.sv
`timescale 1ns/1ps
// ****************************************************************
// Erase sequencer checker
// ****************************************************************
module sfe_erase_props #(
   parameter int unsigned SectorEraseCycles    = 10,
   parameter int unsigned HalfBlockEraseCycles = 10,
   parameter int unsigned BlockEraseCycles     = 10,
   parameter int unsigned ArrayEraseCycles     = 10
) (
   input wire logic               mclk,
   input wire logic               resetn,
   input wire logic               chipSelectN,
   input wire logic               serialClock,
   input wire logic [3:0]         sio,
   input wire logic               quadCommandMode,
   input wire logic               fourByteAddrMode,
   input wire logic               extendedAddrBit,
   input wire logic               protectSchemeSelect,
   input wire logic [3:0]         blockProtectBits,
   input wire logic               bpRegionLocked,
   input wire logic               sectorRegionLocked,
   input wire logic               writeEnableLatch,
   input wire logic               writeInProgressFlag,
   input wire sfe_pkg::sfe_kind_e eraseKind,
   input wire logic [31:0]        eraseAddr,
   input wire logic               eraseSkipLocked,
   input wire logic               cmdRejected
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   int unsigned wipCount;
   int unsigned expCycles;
   // Length of the current busy stretch
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) wipCount <= 0;
      else if (!writeInProgressFlag) wipCount <= 0;
      else wipCount <= wipCount + 1;
   end
   // Erase time belonging to the running kind
   always_comb begin
      case (eraseKind)
         sfe_pkg::SFE_KIND_SECTOR:     expCycles = SectorEraseCycles;
         sfe_pkg::SFE_KIND_HALF_BLOCK: expCycles = HalfBlockEraseCycles;
         sfe_pkg::SFE_KIND_BLOCK:      expCycles = BlockEraseCycles;
         default:                      expCycles = ArrayEraseCycles;
      endcase
   end
   sequence startS;
      $rose(writeInProgressFlag);
   endsequence
   sequence doneS;
      $fell(writeInProgressFlag) && !cmdRejected;
   endsequence
   start_needs_latch_a: assert property (startS |-> writeEnableLatch)
      else $error("erase began without the latch");
   start_after_select_a: assert property (startS |-> chipSelectN
      && $past(chipSelectN, 2)) else $error("erase began inside a frame");
   busy_held_a: assert property (startS ##1 !cmdRejected
      |-> writeInProgressFlag[*8]) else $error("busy flag dropped early");
   erase_time_a: assert property (doneS |-> wipCount + 1 >= expCycles
      && wipCount <= expCycles + 3) else $error("erase time wrong");
   done_clears_latch_a: assert property (doneS |-> !writeEnableLatch)
      else $error("latch kept after erase");
   latch_drop_done_a: assert property ($fell(writeEnableLatch)
      |-> $fell(writeInProgressFlag)) else $error("latch lost while idle");
   refusal_no_run_a: assert property (cmdRejected
      |-> !writeInProgressFlag ##1 !cmdRejected) else $error("bad refusal");
   chip_addr_a: assert property ((startS and
      (eraseKind == sfe_pkg::SFE_KIND_CHIP)) |-> eraseAddr == 32'h0000_0000)
      else $error("chip erase address not zero");
   chip_protect_a: assert property ((startS and (!protectSchemeSelect
      && eraseKind == sfe_pkg::SFE_KIND_CHIP)) ##1 !cmdRejected
      |-> blockProtectBits == 4'h0)
      else $error("chip erase ran under protect bits");
   sector_align_a: assert property ((startS and
      (eraseKind == sfe_pkg::SFE_KIND_SECTOR)) |-> eraseAddr[11:0] == 12'h000)
      else $error("sector base misaligned");
   half_align_a: assert property ((startS and
      (eraseKind == sfe_pkg::SFE_KIND_HALF_BLOCK)) |-> eraseAddr[14:0] == 0)
      else $error("half block base misaligned");
   block_align_a: assert property ((startS and
      (eraseKind == sfe_pkg::SFE_KIND_BLOCK)) |-> eraseAddr[15:0] == 0)
      else $error("block base misaligned");
   skip_flag_a: assert property ((startS and
      (eraseKind == sfe_pkg::SFE_KIND_CHIP))
      |=> eraseSkipLocked == protectSchemeSelect)
      else $error("skip flag wrong");
endmodule : sfe_erase_props

// >>> test/sfe_host_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Flash host driving the link pins
// ****************************************************************
module sfe_host_model (
   input  wire logic  mclk,
   output logic       chipSelectN,
   output logic       serialClock,
   output logic [3:0] sio
);
   // Deselected, clock parked low between frames
   initial begin
      chipSelectN = 1'b1;
      serialClock = 1'b0;
      sio         = 4'h0;
   end
   // One frame, MSB first; serial mode puts noise on the upper lines
   task automatic sendFrame(input logic [39:0] bits, input int nBits,
                            input logic quad);
      int n;
      n = quad ? nBits / 4 : nBits;
      @(negedge mclk) chipSelectN <= 1'b0;
      repeat (4) @(negedge mclk);
      for (int i = 0; i < n; i++) begin
         if (quad) sio <= bits[39 - 4 * i -: 4];
         else sio <= {3'($urandom), bits[39 - i]};
         repeat (4) @(negedge mclk);
         serialClock <= 1'b1;
         repeat (4) @(negedge mclk);
         serialClock <= 1'b0;
      end
      repeat (4) @(negedge mclk);
      chipSelectN <= 1'b1;
      sio <= ~sio;
      repeat (8) @(negedge mclk);
   endtask : sendFrame
endmodule : sfe_host_model

// >>> test/serial_flash_erase_commands_test.sv
`timescale 1ns/1ps
`include "sfe_map.svh"
`define CHK(what, exp, got) begin nTests++; if ((got) !== (exp)) begin \
   badCount++; $display("unexpected %s: expected %0h, seen %0h", \
   what, exp, got); end end
module serial_flash_erase_commands_test;
   typedef struct packed {
      logic               rej;
      sfe_pkg::sfe_kind_e kind;
      logic [31:0]        addr;
   } sfe_note_s;
   logic               mclk, resetn, chipSelectN, serialClock;
   logic [3:0]         sio, blockProtectBits;
   logic               quadCommandMode, fourByteAddrMode, extendedAddrBit;
   logic               protectSchemeSelect, bpRegionLocked;
   logic               sectorRegionLocked, writeEnableLatch;
   logic               writeInProgressFlag, eraseSkipLocked, cmdRejected;
   sfe_pkg::sfe_kind_e eraseKind;
   logic [31:0]        eraseAddr;
   int                 badCount, nTests;
   logic               wipSeen;
   sfe_note_s          noteQ[$];
   logic [7:0] ops [6] = '{`SFE_OP_SECTOR_3B, `SFE_OP_SECTOR_4B,
      `SFE_OP_HALF_BLOCK_3B, `SFE_OP_HALF_BLOCK_4B, `SFE_OP_BLOCK_3B,
      `SFE_OP_BLOCK_4B};
   logic [31:0] masks [3] = '{`SFE_SECTOR_MASK, `SFE_HALF_BLOCK_MASK,
      `SFE_BLOCK_MASK};
   sfe_pkg::sfe_kind_e kinds [3] = '{sfe_pkg::SFE_KIND_SECTOR,
      sfe_pkg::SFE_KIND_HALF_BLOCK, sfe_pkg::SFE_KIND_BLOCK};
   sfe_erase_seq #(.SectorEraseCycles(10), .HalfBlockEraseCycles(12),
      .BlockEraseCycles(14), .ArrayEraseCycles(16)) i_dut (
      .mclk(mclk), .resetn(resetn), .chipSelectN(chipSelectN),
      .serialClock(serialClock), .sio(sio),
      .quadCommandMode(quadCommandMode),
      .fourByteAddrMode(fourByteAddrMode),
      .extendedAddrBit(extendedAddrBit),
      .protectSchemeSelect(protectSchemeSelect),
      .blockProtectBits(blockProtectBits), .bpRegionLocked(bpRegionLocked),
      .sectorRegionLocked(sectorRegionLocked),
      .writeEnableLatch(writeEnableLatch),
      .writeInProgressFlag(writeInProgressFlag), .eraseKind(eraseKind),
      .eraseAddr(eraseAddr), .eraseSkipLocked(eraseSkipLocked),
      .cmdRejected(cmdRejected));
   sfe_host_model i_host (.mclk(mclk), .chipSelectN(chipSelectN),
      .serialClock(serialClock), .sio(sio));
   // 50 MHz clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // Print counts and verdict, then stop
   task automatic summarize();
      $display("checks %0d, mismatches %0d", nTests, badCount);
      if (badCount == 0 && nTests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize
   // Send one frame with the mode pin set to match
   task automatic sendCmd(input logic [7:0] op, input logic [31:0] a,
                          input int nb, input int extra, input logic quad);
      @(negedge mclk) quadCommandMode = quad;
      i_host.sendFrame({op, (nb == 4) ? a : {a[23:0], 8'h00}},
                       8 + 8 * nb + extra, quad);
   endtask : sendCmd
   // One erase attempt with its expected outcome noted first
   task automatic runCase(input logic [7:0] op, input int nb, input int extra,
      input logic quad, input logic wr, input logic acc, input logic rej,
      input sfe_pkg::sfe_kind_e kind, input logic [31:0] mask);
      logic [31:0] a, base;
      a = $urandom;
      if (wr) begin
         sendCmd(`SFE_OP_WRITE_ENABLE, 0, 0, 0, quad);
         `CHK("latch set", 1'b1, writeEnableLatch)
      end
      base = (nb == 4) ? a : {7'h00, extendedAddrBit, a[23:0]};
      if (acc) noteQ.push_back('{1'b0, kind, base & mask});
      if (rej) noteQ.push_back('{1'b1, kind, 32'h0000_0000});
      sendCmd(op, a, nb, extra, quad);
      if (kind == sfe_pkg::SFE_KIND_CHIP && acc && !rej)
         `CHK("skip", protectSchemeSelect, eraseSkipLocked)
      for (int i = 0; i < 100 && writeInProgressFlag; i++) @(negedge mclk);
      if (acc && !rej) `CHK("latch done", 1'b0, writeEnableLatch)
      `CHK("pending", 0, noteQ.size())
      $display("case %h done", op);
   endtask : runCase
   // Match each visible result against the oldest note
   always @(negedge mclk) begin
      sfe_note_s n;
      if (resetn && ((writeInProgressFlag && !wipSeen) || cmdRejected)) begin
         if (noteQ.size() == 0) `CHK("spare result", 1'b0, 1'b1)
         else begin
            n = noteQ.pop_front();
            `CHK("refusal", n.rej, cmdRejected)
            if (!n.rej) `CHK("kind", n.kind, eraseKind)
            if (!n.rej) `CHK("address", n.addr, eraseAddr)
         end
      end
      wipSeen = writeInProgressFlag;
   end
   // Watchdog against a hung run
   initial begin
      repeat (30000) @(posedge mclk);
      badCount++;
      summarize();
   end
   // Main sequence
   initial begin
      {resetn, quadCommandMode, fourByteAddrMode, extendedAddrBit} = 4'h0;
      {protectSchemeSelect, bpRegionLocked, sectorRegionLocked} = 3'h0;
      blockProtectBits = 4'h0;
      {badCount, nTests, wipSeen} = 0;
      void'($urandom(52));
      repeat (20) @(negedge mclk);
      resetn = 1'b1;
      repeat (3) @(negedge mclk);
      `CHK("reset latch", 1'b0, writeEnableLatch)
      `CHK("reset busy", 1'b0, writeInProgressFlag)
      $display("reset case done");
      for (int i = 0; i < 6; i++) begin
         fourByteAddrMode = (i == 2);
         extendedAddrBit = 1'($urandom);
         runCase(ops[i], (i % 2 == 1 || i == 2) ? 4 : 3, 0, i[0], 1, 1, 0,
                 kinds[i / 2], masks[i / 2]);
      end
      fourByteAddrMode = 1'b0;
      for (int j = 0; j < 2; j++) begin
         protectSchemeSelect = j[0];
         blockProtectBits = j[0] ? 4'hF : 4'h0;
         runCase(j[0] ? `SFE_OP_CHIP_ALT : `SFE_OP_CHIP, 0, 0, j[0], 1, 1, 0,
                 sfe_pkg::SFE_KIND_CHIP, 32'h0000_0000);
      end
      {protectSchemeSelect, blockProtectBits} = 5'h00;
      runCase(`SFE_OP_SECTOR_3B, 3, 0, 0, 0, 0, 1, kinds[0], masks[0]);
      runCase(`SFE_OP_SECTOR_3B, 3, -1, 0, 1, 0, 1, kinds[0], masks[0]);
      runCase(`SFE_OP_BLOCK_3B, 3, 4, 1, 1, 0, 1, kinds[2], masks[2]);
      runCase(`SFE_OP_CHIP, 0, 8, 0, 1, 0, 1, sfe_pkg::SFE_KIND_CHIP, 0);
      blockProtectBits = 4'($urandom_range(1, 15));
      runCase(`SFE_OP_CHIP, 0, 0, 1, 1, 1, 1, sfe_pkg::SFE_KIND_CHIP, 0);
      blockProtectBits = 4'h0;
      bpRegionLocked = 1'b1;
      runCase(`SFE_OP_SECTOR_3B, 3, 0, 0, 1, 1, 1, kinds[0], masks[0]);
      {bpRegionLocked, protectSchemeSelect, sectorRegionLocked} = 3'h3;
      runCase(`SFE_OP_HALF_BLOCK_4B, 4, 0, 1, 1, 1, 1, kinds[1],
              masks[1]);
      summarize();
   end
endmodule : serial_flash_erase_commands_test
bind sfe_erase_seq sfe_erase_props #(
   .SectorEraseCycles(SectorEraseCycles),
   .HalfBlockEraseCycles(HalfBlockEraseCycles),
   .BlockEraseCycles(BlockEraseCycles),
   .ArrayEraseCycles(ArrayEraseCycles)) i_props (
   .mclk(mclk), .resetn(resetn), .chipSelectN(chipSelectN),
   .serialClock(serialClock), .sio(sio),
   .quadCommandMode(quadCommandMode),
   .fourByteAddrMode(fourByteAddrMode),
   .extendedAddrBit(extendedAddrBit),
   .protectSchemeSelect(protectSchemeSelect),
   .blockProtectBits(blockProtectBits), .bpRegionLocked(bpRegionLocked),
   .sectorRegionLocked(sectorRegionLocked),
   .writeEnableLatch(writeEnableLatch),
   .writeInProgressFlag(writeInProgressFlag), .eraseKind(eraseKind),
   .eraseAddr(eraseAddr), .eraseSkipLocked(eraseSkipLocked),
   .cmdRejected(cmdRejected));
